// File: core/cbcs_pkg.sv
/*
  constants and types for the bus cycle sequencer.
  assumes one bus clock; cycle numbers count from 1 at the opcode fetch.
*/
// Operation
// - pull index reads high, then low.
// - return takes five cycles, two ignored reads.
// - wait stacks seven bytes in nine cycles.
// - software interrupt twelve cycles, stack seven bytes.
// - vector high from FFFA, low from FFFB.
// - multiply ten cycles, eight dummy FFFF reads.
// - interrupt return reads cc, B, A.
// - then index and next address from stack.
// - branch three cycles; subroutine branch six cycles.
package cbcs_pkg;
  localparam logic [15:0] CBCS_DUMMY_ADDR   = 16'hFFFF;
  localparam logic [15:0] CBCS_VEC_HI_ADDR  = 16'hFFFA;
  localparam logic [15:0] CBCS_VEC_LO_ADDR  = 16'hFFFB;
  localparam logic [3:0]  CBCS_LEN_PULL_IX  = 4'h5;
  localparam logic [3:0]  CBCS_LEN_RET      = 4'h5;
  localparam logic [3:0]  CBCS_LEN_WAIT     = 4'h9;
  localparam logic [3:0]  CBCS_LEN_SOFT_INT = 4'hC;
  localparam logic [3:0]  CBCS_LEN_MULT     = 4'hA;
  localparam logic [3:0]  CBCS_LEN_INT_RET  = 4'hA;
  localparam logic [3:0]  CBCS_LEN_BRANCH   = 4'h3;
  localparam logic [3:0]  CBCS_LEN_BR_SUB   = 4'h6;
  localparam logic [3:0]  CBCS_PUSH_FIRST   = 4'h3;
  localparam logic [3:0]  CBCS_PUSH_LAST    = 4'h9;
  localparam logic [15:0] CBCS_RESET_SP     = 16'h00FF;

  typedef enum logic [2:0] {
    CBCS_OP_PULL_IX  = 3'h0,
    CBCS_OP_RET      = 3'h1,
    CBCS_OP_WAIT     = 3'h2,
    CBCS_OP_SOFT_INT = 3'h3,
    CBCS_OP_MULT     = 3'h4,
    CBCS_OP_INT_RET  = 3'h5,
    CBCS_OP_BRANCH   = 3'h6,
    CBCS_OP_BR_SUB   = 3'h7
  } cbcs_op_e;

  typedef enum logic [0:0] {
    CBCS_IDLE = 1'h0,
    CBCS_RUN  = 1'h1
  } cbcs_state_e;
endpackage : cbcs_pkg

// File: core/cbcs_ctx_if.sv
/*
  interface carrying the register context into the cycle decoder.
  assumes the sequencer owns the context and the decoder only looks.
*/
`timescale 1ns/1ns
interface cbcs_ctx_if;
  logic [2:0]  op;
  logic [3:0]  cyc;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] target;
  logic [15:0] ix;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [7:0]  ccr;
  logic [15:0] addr;
  logic        rw;
  logic [7:0]  wdata;
  modport seq (output op, cyc, pc, sp, target, ix, acc_a, acc_b, ccr, input addr, rw, wdata);
  modport dec (input op, cyc, pc, sp, target, ix, acc_a, acc_b, ccr, output addr, rw, wdata);
endinterface : cbcs_ctx_if

// File: core/cbcs_cycle_dec.sv
/*
  combinational decode of one bus cycle: address, read/write level, write data.
  assumes sp is the pointer value at the opcode fetch and pc the opcode address.
*/
`timescale 1ns/1ns
module cbcs_cycle_dec (
  cbcs_ctx_if.dec ctx
);
  import cbcs_pkg::*;

  wire [15:0] ret_stack_w = ctx.pc + 16'h0001;
  wire [15:0] ret_sub_w   = ctx.pc + 16'h0002;
  wire [15:0] up_w       = ctx.sp + {12'h000, ctx.cyc} - 16'h0003;
  wire [15:0] down_w     = ctx.sp - {12'h000, ctx.cyc} + 16'h0003;
  wire        is_push    = (ctx.op == CBCS_OP_WAIT || ctx.op == CBCS_OP_SOFT_INT) &&
                           ctx.cyc >= CBCS_PUSH_FIRST && ctx.cyc <= CBCS_PUSH_LAST;

  always_comb begin
    ctx.addr  = ctx.pc;
    ctx.rw    = 1'b1;
    ctx.wdata = 8'h00;
    if (ctx.cyc == 4'h1) begin
      ctx.addr = ctx.pc;
    end else if (ctx.cyc == 4'h2) begin
      ctx.addr = ctx.pc + 16'h0001;
    end else begin
      case (ctx.op)
        CBCS_OP_PULL_IX, CBCS_OP_RET, CBCS_OP_INT_RET: begin
          ctx.addr = (ctx.cyc == 4'h3) ? ctx.sp : up_w;
        end
        CBCS_OP_WAIT, CBCS_OP_SOFT_INT: begin
          if (ctx.cyc == 4'hB) begin
            ctx.addr = CBCS_VEC_HI_ADDR;
          end else if (ctx.cyc == 4'hC) begin
            ctx.addr = CBCS_VEC_LO_ADDR;
          end else begin
            ctx.addr = down_w;
          end
          if (is_push) begin
            ctx.rw = 1'b0;
            case (ctx.cyc)
              4'h3: ctx.wdata = ret_stack_w[7:0];
              4'h4: ctx.wdata = ret_stack_w[15:8];
              4'h5: ctx.wdata = ctx.ix[7:0];
              4'h6: ctx.wdata = ctx.ix[15:8];
              4'h7: ctx.wdata = ctx.acc_a;
              4'h8: ctx.wdata = ctx.acc_b;
              default: ctx.wdata = ctx.ccr;
            endcase
          end
        end
        CBCS_OP_MULT, CBCS_OP_BRANCH: begin
          ctx.addr = CBCS_DUMMY_ADDR;
        end
        default: begin
          if (ctx.cyc == 4'h3) begin
            ctx.addr = CBCS_DUMMY_ADDR;
          end else if (ctx.cyc == 4'h4) begin
            ctx.addr = ctx.target;
          end else begin
            ctx.addr  = (ctx.cyc == 4'h5) ? ctx.sp : ctx.sp - 16'h0001;
            ctx.rw    = 1'b0;
            ctx.wdata = (ctx.cyc == 4'h5) ? ret_sub_w[7:0] : ret_sub_w[15:8];
          end
        end
      endcase
    end
  end
endmodule : cbcs_cycle_dec

// File: core/cbcs_seq.sv
/*
  top of the bus cycle sequencer: takes one instruction start and walks its cycles.
  assumes memory answers every read and stores every write, one cycle each.
*/
`timescale 1ns/1ns
module cbcs_seq (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             start_in,
  input  wire cbcs_pkg::cbcs_op_e op_in,
  input  wire logic [15:0]      pc_in,
  input  wire logic [15:0]      sp_in,
  input  wire logic [15:0]      target_in,
  input  wire logic [15:0]      ix_in,
  input  wire logic [7:0]       acc_a_in,
  input  wire logic [7:0]       acc_b_in,
  input  wire logic [7:0]       ccr_in,
  input  wire logic [7:0]       data_in,
  output logic      [15:0]      addr_out,
  output logic                  rw_out,
  output logic      [7:0]       data_out,
  output logic                  busy_out,
  output logic                  done_out,
  output logic      [15:0]      sp_out,
  output logic      [15:0]      result_out
);
  import cbcs_pkg::*;

  // ----------------------------------------
  // context and counter
  // ----------------------------------------
  cbcs_ctx_if ctx ();
  cbcs_state_e state_reg;
  logic [2:0]  op_reg;
  logic [3:0]  cyc_reg;
  logic [15:0] pc_reg, sp_reg, target_reg, ix_reg, result_reg;
  logic [7:0]  a_reg, b_reg, c_reg;

  assign ctx.op     = op_reg;
  assign ctx.cyc    = cyc_reg;
  assign ctx.pc     = pc_reg;
  assign ctx.sp     = sp_reg;
  assign ctx.target = target_reg;
  assign ctx.ix     = ix_reg;
  assign ctx.acc_a  = a_reg;
  assign ctx.acc_b  = b_reg;
  assign ctx.ccr    = c_reg;

  cbcs_cycle_dec u_dec (
    .ctx (ctx)
  );

  wire [3:0] len_w = (op_reg == CBCS_OP_PULL_IX)  ? CBCS_LEN_PULL_IX  :
                     (op_reg == CBCS_OP_RET)      ? CBCS_LEN_RET      :
                     (op_reg == CBCS_OP_WAIT)     ? CBCS_LEN_WAIT     :
                     (op_reg == CBCS_OP_SOFT_INT) ? CBCS_LEN_SOFT_INT :
                     (op_reg == CBCS_OP_MULT)     ? CBCS_LEN_MULT     :
                     (op_reg == CBCS_OP_INT_RET)  ? CBCS_LEN_INT_RET  :
                     (op_reg == CBCS_OP_BRANCH)   ? CBCS_LEN_BRANCH   : CBCS_LEN_BR_SUB;
  wire last_w = (state_reg == CBCS_RUN) && (cyc_reg == len_w);
  wire is_pop = (op_reg == CBCS_OP_PULL_IX || op_reg == CBCS_OP_RET || op_reg == CBCS_OP_INT_RET);
  wire push_w = (op_reg == CBCS_OP_WAIT || op_reg == CBCS_OP_SOFT_INT) ? 1'b1 : 1'b0;
  // pointer left after the instruction: pushes end one below last write
  wire [15:0] sp_end_w = push_w ? sp_reg - 16'h0007 :
                         (op_reg == CBCS_OP_BR_SUB) ? sp_reg - 16'h0002 :
                         (op_reg == CBCS_OP_INT_RET) ? sp_reg + 16'h0007 :
                         is_pop ? sp_reg + 16'h0002 : sp_reg;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg <= CBCS_IDLE;
      cyc_reg   <= 4'h1;
      op_reg    <= 3'h0;
    end else if (state_reg == CBCS_IDLE) begin
      if (start_in) begin
        state_reg <= CBCS_RUN;
        cyc_reg   <= 4'h1;
        op_reg    <= op_in;
      end
    end else if (last_w) begin
      state_reg <= CBCS_IDLE;
      cyc_reg   <= 4'h1;
    end else begin
      cyc_reg <= cyc_reg + 4'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pc_reg     <= 16'h0000;
      sp_reg     <= CBCS_RESET_SP;
      target_reg <= 16'h0000;
      ix_reg     <= 16'h0000;
      a_reg      <= 8'h00;
      b_reg      <= 8'h00;
      c_reg      <= 8'h00;
    end else if (state_reg == CBCS_IDLE && start_in) begin
      pc_reg     <= pc_in;
      sp_reg     <= sp_in;
      target_reg <= target_in;
      ix_reg     <= ix_in;
      a_reg      <= acc_a_in;
      b_reg      <= acc_b_in;
      c_reg      <= ccr_in;
    end
  end

  // ----------------------------------------
  // registered bus outputs
  // ----------------------------------------
  // outputs trail the decode by one edge so every pin comes from a flop
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      addr_out <= CBCS_DUMMY_ADDR;
      rw_out   <= 1'b1;
      data_out <= 8'h00;
      busy_out <= 1'b0;
    end else begin
      addr_out <= (state_reg == CBCS_RUN) ? ctx.addr : CBCS_DUMMY_ADDR;
      rw_out   <= (state_reg == CBCS_RUN) ? ctx.rw : 1'b1;
      data_out <= ctx.wdata;
      busy_out <= (state_reg == CBCS_RUN);
    end
  end

  // read data is taken at the edge that ends the bus cycle showing the read
  logic       cap_reg;
  logic [3:0] cap_cyc_reg;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cap_reg     <= 1'b0;
      cap_cyc_reg <= 4'h0;
      result_reg  <= 16'h0000;
      done_out    <= 1'b0;
      sp_out      <= CBCS_RESET_SP;
    end else begin
      cap_reg     <= (state_reg == CBCS_RUN) && is_pop;
      cap_cyc_reg <= cyc_reg;
      done_out    <= last_w;
      if (last_w) begin
        sp_out <= sp_end_w;
      end
      if (cap_reg && (cap_cyc_reg == 4'h4 || cap_cyc_reg == 4'h9)) begin
        result_reg[15:8] <= data_in;
      end
      if (cap_reg && (cap_cyc_reg == 4'h5 || cap_cyc_reg == 4'hA)) begin
        result_reg[7:0] <= data_in;
      end
    end
  end
  assign result_out = result_reg;
endmodule : cbcs_seq

// File: test/cbcs_seq_properties.sv
/* pin assertions for the sequencer.
   assumes bind to cbcs_seq; bench keeps pc and target away from FFFA..FFFF. */
`timescale 1ns/1ns
module cbcs_seq_properties (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        start_in,
  input wire logic [15:0] addr_out,
  input wire logic        rw_out,
  input wire logic        busy_out,
  input wire logic        done_out
);
  logic [3:0] run_reg;
  logic [3:0] run_next;
  // counter, not a long repetition, keeps the tools fast
  assign run_next = busy_out ? run_reg + 4'h1 : 4'h0;
  always_ff @(posedge clock_in) begin
    run_reg <= rst_n_in ? run_next : 4'h0;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_IDLE_BUS: assert property (!busy_out |-> addr_out == 16'hFFFF && rw_out)
    else $error("idle bus not parked");
  AST_PUSH_DEC: assert property (busy_out && !rw_out && $past(busy_out && !rw_out)
    |-> addr_out == $past(addr_out) - 16'h1) else $error("push not downward");
  AST_VEC_LO: assert property (busy_out && addr_out == 16'hFFFA
    |=> addr_out == 16'hFFFB && rw_out && done_out) else $error("vector low missing");
  AST_VEC_PRE: assert property (busy_out && addr_out == 16'hFFFA |-> rw_out && !$past(rw_out, 2)
    && $past(addr_out) == $past(addr_out, 2) - 16'h1) else $error("vector not after sp-7");
  AST_MUL_RUN: assert property (done_out && addr_out == 16'hFFFF && $past(addr_out) == 16'hFFFF
    |-> $past(addr_out, 7) == 16'hFFFF && $past(busy_out, 7)) else $error("dummy run short");
  AST_DONE_END: assert property (done_out |-> busy_out ##1 (!busy_out && !done_out))
    else $error("done not on last cycle");
  AST_START_LAT: assert property ($rose(busy_out) |-> $past(start_in, 2))
    else $error("start latency");
  AST_LEN_MAX: assert property (busy_out |-> run_reg < 4'hC)
    else $error("instruction too long");
  COV_VECTOR: cover property (done_out && addr_out == 16'hFFFB);
  COV_DUMMY: cover property (done_out && addr_out == 16'hFFFF);
  COV_PUSH: cover property (busy_out && !rw_out);
endmodule : cbcs_seq_properties

// File: test/cbcs_mem.sv
/* external memory model on the processor bus.
   assumes read data must stand before the edge that ends the read cycle;
   it answers on the falling edge, inside the cycle that shows the read. */
`timescale 1ns/1ns
module cbcs_mem (
  input  wire logic        clock_in,
  input  wire logic        busy_in,
  input  wire logic        rw_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [logic [15:0]];
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction : pat
  initial rdata_out = 8'h00;
  always @(negedge clock_in) begin
    if (busy_in && !rw_in) begin
      mem[addr_in] = wdata_in;
    end
    // released bus flips so a stale byte never looks valid
    if (busy_in && rw_in) begin
      rdata_out <= mem.exists(addr_in) ? mem[addr_in] : pat(addr_in);
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule : cbcs_mem

// File: test/cbcs_seq_bench.sv
/* self-checking bench: walks every instruction kind with random context.
   assumes cbcs_pkg, cbcs_seq and cbcs_mem compiled first. */
`timescale 1ns/1ns
module cbcs_seq_bench;
  import cbcs_pkg::*;
  logic clock_in, rst_n_in, start_in;
  cbcs_op_e op_in;
  logic [15:0] pc_in, sp_in, target_in, ix_in, addr_out, sp_out, result_out;
  logic [7:0]  acc_a_in, acc_b_in, ccr_in, data_in, data_out;
  logic        rw_out, busy_out, done_out;
  logic [25:0] exp_q[$];
  logic [25:0] e;
  logic [31:0] lfsr;
  int          n_fail, samples_checked, n;
  always #5 clock_in = ~clock_in;
  cbcs_seq u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in),
    .pc_in(pc_in), .sp_in(sp_in), .target_in(target_in), .ix_in(ix_in), .acc_a_in(acc_a_in),
    .acc_b_in(acc_b_in), .ccr_in(ccr_in), .data_in(data_in), .addr_out(addr_out), .rw_out(rw_out),
    .data_out(data_out), .busy_out(busy_out), .done_out(done_out), .sp_out(sp_out),
    .result_out(result_out));
  cbcs_mem u_mem (.clock_in(clock_in), .busy_in(busy_out), .rw_in(rw_out), .addr_in(addr_out),
    .wdata_in(data_out), .rdata_out(data_in));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task put(input logic rw, input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({~rw, rw, a, d});
  endtask : put
  task close_out;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // monitor takes one note per shown bus cycle
  always @(negedge clock_in) begin
    if (busy_out === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 26'h0;
      chk("addr", addr_out, e[23:8]);
      chk("rw", {15'h0, rw_out}, {15'h0, e[24]});
      if (e[25]) chk("wdata", {8'h0, data_out}, {8'h0, e[7:0]});
    end
  end
  task run(input cbcs_op_e op);
    logic [31:0] r;
    logic [15:0] pc, sp, rs, sx;
    logic [55:0] wr;
    logic        pk, sk;
    int          i;
    int          np;
    r = rnd();
    pc = {4'h1, r[11:0]};
    sp = {(op inside {CBCS_OP_WAIT, CBCS_OP_SOFT_INT, CBCS_OP_BR_SUB}) ? 4'h8 : 4'h2, r[27:16]};
    op_in = op;
    {pc_in, sp_in, target_in} = {pc, sp, 4'h1, r[23:12]};
    r = rnd();
    {ix_in, acc_a_in, acc_b_in, ccr_in} = {r, r[7:0] ^ 8'h3C};
    wr = {ccr_in, acc_b_in, acc_a_in, ix_in, pc + 16'h1};
    {pk, sk, rs, sx} = {2'b01, 16'h0, sp - 16'h7};
    put(1'b1, pc, 8'h0);
    put(1'b1, pc + 16'h1, 8'h0);
    case (op)
      CBCS_OP_PULL_IX, CBCS_OP_RET, CBCS_OP_INT_RET: begin
        i = (op == CBCS_OP_INT_RET) ? 5 : 0;
        for (int k = 0; k <= i + 2; k++) put(1'b1, sp + k[15:0], 8'h0);
        rs = {u_mem.pat(sp + i[15:0] + 16'h1), u_mem.pat(sp + i[15:0] + 16'h2)};
        {pk, sx} = {1'b1, sp + i[15:0] + 16'h2};
      end
      CBCS_OP_WAIT, CBCS_OP_SOFT_INT: begin
        for (int k = 0; k < 7; k++) put(1'b0, sp - k[15:0], wr[8*k +: 8]);
        if (op == CBCS_OP_SOFT_INT) put(1'b1, sp - 16'h7, 8'h0);
        if (op == CBCS_OP_SOFT_INT) put(1'b1, 16'hFFFA, 8'h0);
        if (op == CBCS_OP_SOFT_INT) put(1'b1, 16'hFFFB, 8'h0);
      end
      CBCS_OP_MULT: begin
        repeat (8) put(1'b1, 16'hFFFF, 8'h0);
        sx = sp;
      end
      default: begin
        put(1'b1, 16'hFFFF, 8'h0);
        if (op == CBCS_OP_BR_SUB) begin
          put(1'b1, target_in, 8'h0);
          put(1'b0, sp, pc[7:0] + 8'h2);
          put(1'b0, sp - 16'h1, wr[15:8] + {7'h0, wr[7:0] == 8'hFF});
        end
        sx = (op == CBCS_OP_BR_SUB) ? sp - 16'h2 : sp;
      end
    endcase
    np = exp_q.size();
    start_in = 1'b1;
    i = 0;
    while (done_out !== 1'b1 && i < 40) begin
      @(posedge clock_in);
      #1 i++;
    end
    start_in = 1'b0;
    if (i == 40) chk("timeout", 16'h1, 16'h0);
    if (i == 40) close_out;
    chk("done", 16'(i), 16'(np + 1));
    repeat (2) @(posedge clock_in);
    #1 chk("cycles", 16'(exp_q.size()), 16'h0);
    if (pk) chk("result", result_out, rs);
    if (sk) chk("sp", sp_out, sx);
  endtask : run
  initial begin
    {clock_in, rst_n_in, start_in} = 3'b000;
    op_in = CBCS_OP_PULL_IX;
    {pc_in, sp_in, target_in, ix_in, acc_a_in, acc_b_in, ccr_in} = 88'h0;
    {lfsr, n_fail, samples_checked} = {32'hB09D, 64'h0};
    repeat (4) @(posedge clock_in);
    #1 chk("rst addr", addr_out, 16'hFFFF);
    chk("rst sp", sp_out, 16'h00FF);
    chk("rst busy", {15'h0, busy_out}, 16'h0);
    rst_n_in = 1'b1;
    for (n = 0; n < 24; n++) run(cbcs_op_e'(n % 8));
    close_out;
  end
endmodule : cbcs_seq_bench
bind cbcs_seq cbcs_seq_properties u_props (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in),
  .addr_out(addr_out), .rw_out(rw_out), .busy_out(busy_out), .done_out(done_out));
